// File: hw/sbs_status.sv
// serial bus status flags with apb register access and start/stop detect
`timescale 1ns/10ps
module sbs_status
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire sbs_pkg::sbs_evt_t i_evt,
    output logic [7:0] o_tx_byte,
    output logic o_tx_full
);
    // ************************************************************
    // pin synchronisers and bus condition detect
    // ************************************************************
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    // two flops per pin plus an edge flop on sda; edge logic compares the second and third sda stages
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_m <= i_scl;
            scl_s <= scl_m;
            sda_m <= i_sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // sda moving while scl is high marks start or stop
    wire start_det = scl_s & sda_d & ~sda_s;
    wire stop_det = scl_s & ~sda_d & sda_s;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable;
    wire hit_stat = (i_paddr == sbs_pkg::SBS_ADDR_STATUS);
    wire hit_tx = (i_paddr == sbs_pkg::SBS_ADDR_TX);
    wire hit_rx = (i_paddr == sbs_pkg::SBS_ADDR_RX);
    wire mapped = hit_stat | hit_tx | hit_rx;
    wire wr_stat = access & i_pwrite & hit_stat;
    wire wr_tx = access & i_pwrite & hit_tx;
    wire rd_rx = access & ~i_pwrite & hit_rx;
    // zero wait states: every access phase completes at once
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~mapped;

    // ************************************************************
    // status flags
    // ************************************************************
    logic ack_result_flag;
    logic master_tx_active;
    logic bus_collision_flag;
    logic general_call_seen;
    logic ten_bit_match;
    logic write_collision_flag;
    logic rx_overflow_flag;
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic slave_read;
    logic rx_full;
    logic tx_full;
    logic [7:0] tx_data_reg;
    logic [7:0] rx_data_reg;

    // a busy write is refused; the old tx byte stays untouched
    wire tx_ok = wr_tx & ~i_evt.busy;               // [R6]
    wire tx_refused = wr_tx & i_evt.busy;           // [R6]
    // an unread byte blocks the transfer and flags overflow
    wire rx_store = i_evt.rx_valid & ~rx_full;      // [R7]
    wire rx_lost = i_evt.rx_valid & rx_full;        // [R7]
    // software clear: a zero written into a clearable bit
    wire clr_bcl = wr_stat & ~i_pwdata[sbs_pkg::SBS_B_BCL];    // [R15]
    wire clr_wcol = wr_stat & ~i_pwdata[sbs_pkg::SBS_B_WCOL];  // [R15]
    wire clr_rov = wr_stat & ~i_pwdata[sbs_pkg::SBS_B_ROV];    // [R15]

    // master transmit tracking
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_result_flag <= 1'b0;
            master_tx_active <= 1'b0;
        end
        else
        begin
            if (i_evt.ack_end)
            begin
                ack_result_flag <= i_evt.ack_nack;  // [R1]
            end
            if (i_evt.tx_start)
            begin
                master_tx_active <= 1'b1;           // [R2]
            end
            else if (i_evt.ack_end)
            begin
                master_tx_active <= 1'b0;           // [R2]
            end
        end
    end

    // sticky error flags; set beats a clear in the same cycle
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bus_collision_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            rx_overflow_flag <= 1'b0;
        end
        else
        begin
            bus_collision_flag <= i_evt.collision | (bus_collision_flag & ~clr_bcl);  // [R3]
            write_collision_flag <= tx_refused | (write_collision_flag & ~clr_wcol);  // [R6]
            rx_overflow_flag <= rx_lost | (rx_overflow_flag & ~clr_rov);           // [R7]
        end
    end

    // address and bus condition flags
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            general_call_seen <= 1'b0;
            ten_bit_match <= 1'b0;
            data_not_addr <= 1'b0;
            stop_seen <= 1'b0;
            start_seen <= 1'b0;
            slave_read <= 1'b0;
        end
        else
        begin
            general_call_seen <= i_evt.gc_match | (general_call_seen & ~stop_det);  // [R4]
            ten_bit_match <= i_evt.t10_match | (ten_bit_match & ~stop_det);         // [R5]
            if (i_evt.slave_data)
            begin
                data_not_addr <= 1'b1;              // [R8]
            end
            else if (i_evt.addr_match)
            begin
                data_not_addr <= 1'b0;              // [R8]
            end
            if (start_det | stop_det)
            begin
                stop_seen <= stop_det;              // [R9]
                start_seen <= start_det;            // [R10]
            end
            if (i_evt.addr_match)
            begin
                slave_read <= i_evt.addr_rw;        // [R11]
            end
        end
    end

    // data registers and their full flags
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_full <= 1'b0;
            tx_full <= 1'b0;
            tx_data_reg <= sbs_pkg::SBS_BYTE_RESET;
            rx_data_reg <= sbs_pkg::SBS_BYTE_RESET;
        end
        else
        begin
            rx_full <= rx_store | (rx_full & ~rd_rx);     // [R12]
            tx_full <= tx_ok | (tx_full & ~i_evt.tx_done); // [R13]
            if (rx_store)
            begin
                rx_data_reg <= i_evt.rx_byte;             // [R12]
            end
            if (tx_ok)
            begin
                tx_data_reg <= i_pwdata[7:0];             // [R13]
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [15:0] status_word;
    // bits 13 to 11 stay zero from the reset constant
    always_comb
    begin
        status_word = sbs_pkg::SBS_STATUS_RESET;       // [R14]
        status_word[sbs_pkg::SBS_B_ACK] = ack_result_flag;
        status_word[sbs_pkg::SBS_B_TRS] = master_tx_active;
        status_word[sbs_pkg::SBS_B_BCL] = bus_collision_flag;
        status_word[sbs_pkg::SBS_B_GC] = general_call_seen;
        status_word[sbs_pkg::SBS_B_T10] = ten_bit_match;
        status_word[sbs_pkg::SBS_B_WCOL] = write_collision_flag;
        status_word[sbs_pkg::SBS_B_ROV] = rx_overflow_flag;
        status_word[sbs_pkg::SBS_B_DA] = data_not_addr;
        status_word[sbs_pkg::SBS_B_STOP] = stop_seen;
        status_word[sbs_pkg::SBS_B_START] = start_seen;
        status_word[sbs_pkg::SBS_B_RW] = slave_read;
        status_word[sbs_pkg::SBS_B_RXF] = rx_full;
        status_word[sbs_pkg::SBS_B_TXF] = tx_full;
    end

    wire [31:0] rd_mux = hit_stat ? {16'h0000, status_word} :
                         hit_tx ? {24'h00_0000, tx_data_reg} :
                         hit_rx ? {24'h00_0000, rx_data_reg} : 32'h0000_0000;

    // data captured in setup so the access phase shows it from a flop
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_prdata <= 32'h0000_0000;
        end
        else if (setup)
        begin
            o_prdata <= rd_mux;
        end
    end

    assign o_tx_byte = tx_data_reg;
    assign o_tx_full = tx_full;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    property p_ack;
        i_evt.ack_end |=> ack_result_flag == $past(i_evt.ack_nack);
    endproperty
    a_ack: assert property (p_ack) else $error("ack flag not updated"); // [R1]

    property p_trs;
        i_evt.ack_end && !i_evt.tx_start |=> !master_tx_active;
    endproperty
    a_trs: assert property (p_trs) else $error("tx active not cleared"); // [R2]

    property p_bcl;
        i_evt.collision |=> bus_collision_flag ##1 (bus_collision_flag || $past(clr_bcl));
    endproperty
    a_bcl: assert property (p_bcl) else $error("collision flag lost"); // [R3]

    property p_gc;
        stop_det && !i_evt.gc_match |=> !general_call_seen;
    endproperty
    a_gc: assert property (p_gc) else $error("general call not cleared on stop"); // [R4]

    property p_t10;
        i_evt.t10_match |=> ten_bit_match;
    endproperty
    a_t10: assert property (p_t10) else $error("ten bit match not set"); // [R5]

    property p_wcol;
        tx_refused |=> write_collision_flag && tx_data_reg == $past(tx_data_reg);
    endproperty
    a_wcol: assert property (p_wcol) else $error("busy write not refused"); // [R6]

    property p_rov;
        rx_lost |=> rx_overflow_flag && $stable(rx_data_reg);
    endproperty
    a_rov: assert property (p_rov) else $error("overflow not flagged"); // [R7]

    property p_cond;
        stop_det |=> stop_seen && !start_seen;
    endproperty
    a_cond: assert property (p_cond) else $error("stop not recorded"); // [R9]

    property p_start;
        start_det |=> start_seen && !stop_seen;
    endproperty
    a_start: assert property (p_start) else $error("start not recorded"); // [R10]

    property p_rbf;
        rd_rx && !rx_store |=> !rx_full;
    endproperty
    a_rbf: assert property (p_rbf) else $error("rx full not cleared by read"); // [R12]

    property p_tbf;
        tx_ok |=> tx_full && o_tx_byte == $past(i_pwdata[7:0]);
    endproperty
    a_tbf: assert property (p_tbf) else $error("tx write not taken"); // [R13]

    property p_resv;
        access && hit_stat |-> o_prdata[13:11] == 3'b000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero"); // [R14]

    property p_setwin;
        i_evt.collision && clr_bcl |=> bus_collision_flag;
    endproperty
    a_setwin: assert property (p_setwin) else $error("clear beat the set"); // [R15]

    c_start: cover property (start_det ##[1:200] stop_det);
    c_ovf: cover property (rx_lost);
    c_wcol: cover property (tx_refused);
endmodule

// File: hw/sbs_pkg.sv
// package for the serial bus status flag block
//
// Contract
// (R1) master tx: ack_result_flag gets 1 on NACK, 0 on ACK, at ack slot end.
// (R2) master_tx_active rises at master tx start, falls at end of slave ack.
// (R3) bus_collision_flag set on master bus collision, held until software clears.
// (R4) general_call_seen set on general call address match, cleared on Stop.
// (R5) ten_bit_match set on second ten-bit address byte match, cleared on Stop.
// (R6) tx_data_reg write while busy is dropped and sets write_collision_flag.
// (R7) byte ready while rx_data_reg still unread sets rx_overflow_flag.
// (R8) data-or-address flag cleared on own address match, set on slave data byte.
// (R9) stop-seen flag is 1 if Stop was last condition, 0 after Start.
// (R10) start-seen flag is 1 if Start was last condition, 0 after Stop.
// (R11) direction flag takes the read/write bit of the received slave address.
// (R12) rx_full set when rx_data_reg is loaded, cleared when software reads it.
// (R13) tx_full set on tx_data_reg write, cleared when transmission completes.
// (R14) status bits 13 to 11 read zero; all flags reset to zero.
// (R15) clearable flags: write 0 clears, write 1 keeps, hardware set wins.
package sbs_pkg;
    // ************************************************************
    // register map, byte addresses on the apb
    // ************************************************************
    localparam logic [7:0] SBS_ADDR_STATUS = 8'h00;
    localparam logic [7:0] SBS_ADDR_TX = 8'h04;
    localparam logic [7:0] SBS_ADDR_RX = 8'h08;
    localparam logic [15:0] SBS_STATUS_RESET = 16'h0000;
    localparam logic [7:0] SBS_BYTE_RESET = 8'h00;
    // ************************************************************
    // status field positions
    // ************************************************************
    localparam int SBS_B_ACK = 15;
    localparam int SBS_B_TRS = 14;
    localparam int SBS_B_BCL = 10;
    localparam int SBS_B_GC = 9;
    localparam int SBS_B_T10 = 8;
    localparam int SBS_B_WCOL = 7;
    localparam int SBS_B_ROV = 6;
    localparam int SBS_B_DA = 5;
    localparam int SBS_B_STOP = 4;
    localparam int SBS_B_START = 3;
    localparam int SBS_B_RW = 2;
    localparam int SBS_B_RXF = 1;
    localparam int SBS_B_TXF = 0;
    // ************************************************************
    // events from the bus engine, same clock as the block
    // ************************************************************
    typedef struct packed {
        logic ack_end;      // end of slave acknowledge slot
        logic ack_nack;     // sampled ack bit, 1 = nack
        logic tx_start;     // master transmission begins
        logic collision;    // bus collision in master operation
        logic addr_match;   // own slave address matched
        logic addr_rw;      // r/w bit of that address byte
        logic gc_match;     // general call address received
        logic t10_match;    // second ten-bit address byte matched
        logic slave_data;   // data byte received as slave
        logic rx_valid;     // shifted byte ready for rx_data_reg
        logic [7:0] rx_byte;
        logic tx_done;      // data transmission complete
        logic busy;         // module busy, tx writes refused
    } sbs_evt_t;
endpackage

// File: test/sbs_bus_node.sv
// behavioural model of another node driving the two-wire bus lines
`timescale 1ns/10ps
module sbs_bus_node
(
    output logic o_scl,
    output logic o_sda
);
    // both lines rest at the pull-up level; the clock stands still outside frames
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // start or repeated start: data falls while the clock is high
    task automatic do_start();
        o_sda = 1'b1;
        #24 o_scl = 1'b1;
        #24 o_sda = 1'b0;
        #24 o_scl = 1'b0;
    endtask

    // data only moves while the clock is low, so no false conditions appear
    task automatic do_bits(input int n);
        for (int i = 0; i < n; i++)
        begin
            o_sda = i[0];
            #24 o_scl = 1'b1;
            #24 o_scl = 1'b0;
        end
    endtask

    // stop: data rises while the clock is high, then both lines rest high
    task automatic do_stop();
        o_sda = 1'b0;
        #24 o_scl = 1'b1;
        #24 o_sda = 1'b1;
        #24;
    endtask
endmodule

// File: test/tb.sv
// self-checking bench for the serial bus status flag block
`timescale 1ns/10ps
module tb;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    logic scl;
    logic sda;
    logic [7:0] tx_byte;
    logic tx_full;
    sbs_pkg::sbs_evt_t evt = '0;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    sbs_status dut_u
    (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_psel(psel),
        .i_penable(penable),
        .i_pwrite(pwrite),
        .i_paddr(paddr),
        .i_pwdata(pwdata),
        .o_prdata(prdata),
        .o_pready(pready),
        .o_pslverr(pslverr),
        .i_scl(scl),
        .i_sda(sda),
        .i_evt(evt),
        .o_tx_byte(tx_byte),
        .o_tx_full(tx_full)
    );

    sbs_bus_node node_u
    (
        .o_scl(scl),
        .o_sda(sda)
    );

    // 200 MHz system clock
    initial
    begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    // ************************************************************
    // access tasks
    // ************************************************************
    // one apb transfer; held until pready is seen high at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0000_0000, r);
        chk(nm, exp, r);
    endtask

    // one-cycle event pulse from the bus engine
    task automatic fire(input sbs_pkg::sbs_evt_t e);
        @(posedge i_sys_clk);
        evt <= e;
        @(posedge i_sys_clk);
        evt <= '0;
    endtask

    // bus conditions need the synchroniser and edge flop to settle
    task automatic settle();
        repeat (6) @(posedge i_sys_clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch and ends the run
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial
    begin
        sbs_pkg::sbs_evt_t e;
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000, "status reset");
        wr(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_FFFF);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000, "status ro bits");
        rd(8'h0C, 32'h0000_0000, "unmapped data");
        chk("unmapped error", 32'h0000_0001, {31'h0, last_err});
        // transmit register load, then a refused write while busy
        wr(sbs_pkg::SBS_ADDR_TX, 32'h0000_00A5);
        // pins are looked at mid-cycle, after the access edge has updated them
        @(negedge i_sys_clk);
        chk("tx full pin", 32'h0000_0001, {31'h0, tx_full});
        chk("tx byte pin", 32'h0000_00A5, {24'h0, tx_byte});
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0001, "status tx full");
        @(posedge i_sys_clk);
        evt.busy <= 1'b1;
        wr(sbs_pkg::SBS_ADDR_TX, 32'h0000_003C);
        evt.busy <= 1'b0;
        @(negedge i_sys_clk);
        chk("tx byte kept", 32'h0000_00A5, {24'h0, tx_byte});
        rd(sbs_pkg::SBS_ADDR_TX, 32'h0000_00A5, "tx reg");
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0081, "status wcol");
        wr(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_FFFF);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0081, "status keep");
        wr(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0001, "status clr");
        e = '0;
        e.tx_done = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000, "status tx done");
        // master transmit progress and acknowledge result
        e = '0;
        e.tx_start = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_4000, "status tx active");
        e = '0;
        e.ack_end = 1'b1;
        e.ack_nack = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_8000, "status nack");
        e.ack_nack = 1'b0;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000, "status ack");
        e = '0;
        e.collision = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0400, "status collision");
        wr(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000, "status bcl clr");
        // receive path with an overflow
        e = '0;
        e.rx_valid = 1'b1;
        e.rx_byte = 8'h5A;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0002, "status rx full");
        e.rx_byte = 8'h77;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0042, "status overflow");
        rd(sbs_pkg::SBS_ADDR_RX, 32'h0000_005A, "rx byte");
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0040, "status rx read");
        wr(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000);
        // slave address and data bytes
        e = '0;
        e.addr_match = 1'b1;
        e.addr_rw = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0004, "status slave read");
        e = '0;
        e.slave_data = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0024, "status data byte");
        e = '0;
        e.addr_match = 1'b1;
        fire(e);
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0000, "status slave write");
        // bus conditions from the far node
        node_u.do_start();
        settle();
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0008, "status start");
        e = '0;
        e.gc_match = 1'b1;
        e.t10_match = 1'b1;
        fire(e);
        node_u.do_bits(9);
        node_u.do_start();
        settle();
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0308, "status rep start");
        node_u.do_stop();
        settle();
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0010, "status stop");
        node_u.do_start();
        settle();
        rd(sbs_pkg::SBS_ADDR_STATUS, 32'h0000_0008, "status restart");
        node_u.do_stop();
        wrap_up();
    end
endmodule
